// *** hw/brc_pkg.sv ***
`default_nettype none
// ****************************************************************
// Burst ROM area configuration constants and carriers
// ****************************************************************
package brc_pkg;
  localparam int          BRC_DATA_W       = 16;
  localparam logic [15:0] BRC_RESET_VALUE  = 16'h0000;
  // Writable bits; reserved 11, 10, 3, 2 are excluded
  localparam logic [15:0] BRC_WRITE_MASK   = 16'hF3F3;
  localparam int          BRC_A0_SEL_POS   = 15;
  localparam int          BRC_A0_CYC_POS   = 12;
  localparam int          BRC_A0_WRD_POS   = 8;
  localparam int          BRC_A1_SEL_POS   = 7;
  localparam int          BRC_A1_CYC_POS   = 4;
  localparam int          BRC_A1_WRD_POS   = 0;
  localparam int          BRC_CYC_W        = 3;
  localparam int          BRC_WRD_W        = 2;
  localparam int          BRC_BEATS_W      = 4;
  localparam int          BRC_WORDS_W      = 6;
  localparam logic [5:0]  BRC_MIN_WORDS    = 6'h04;

  // Interface kind applied to one area
  typedef enum logic [1:0] {
    BRC_IF_BASIC,
    BRC_IF_BYTE_SRAM,
    BRC_IF_BURST_ROM
  } brc_if_e;

  // Decoded settings of one area
  typedef struct packed {
    brc_if_e     if_kind;
    logic [3:0]  burst_cycles;
    logic [5:0]  burst_words;
  } brc_area_s;

  // Register write request
  typedef struct packed {
    logic        wr_en;
    logic [15:0] wr_data;
  } brc_wr_s;
endpackage
`default_nettype wire

// *** hw/brc_regs.sv ***
`default_nettype none
// ****************************************************************
// Burst ROM control register with decoded per-area settings
// ****************************************************************
// Overview of operation
// [RQ1] Bit 15 set selects burst ROM interface for area 0.
// [RQ2] Software clears area 0 byte SRAM select before setting burst ROM select.
// [RQ3] Bits 14:12 give area 0 burst cycle length, code plus one.
// [RQ4] Bits 9:8 give area 0 burst word limit: 4, 8, 16, 32.
// [RQ5] Bit 7 set selects burst ROM interface for area 1.
// [RQ6] Software clears area 1 byte SRAM select before setting burst ROM select.
// [RQ7] Bits 6:4 give area 1 burst cycle length, code plus one.
// [RQ8] Bits 1:0 give area 1 burst word limit: 4, 8, 16, 32.
// [RQ9] Reserved bits 11, 10, 3, 2 read zero and ignore writes.
// [RQ10] Reset clears every field to zero.
// [RQ11] Byte SRAM select makes the area use the byte SRAM interface.
// [RQ12] New settings apply only to accesses starting after the write.
module brc_regs
  import brc_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // Register port
  input  wire brc_wr_s   wr_req,
  output logic [15:0]    rd_data,
  // Byte SRAM selects from the SRAM mode register
  input  wire logic      area0_byte_sram_select,
  input  wire logic      area1_byte_sram_select,
  // Access start strobes from the external access sequencer
  input  wire logic      area0_access_start,
  input  wire logic      area1_access_start,
  // Settings latched for the running access
  output brc_area_s      area0_cfg,
  output brc_area_s      area1_cfg
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0] burst_rom_control;
    brc_area_s   a0;
    brc_area_s   a1;
  } brc_state_s;

  brc_state_s st;
  brc_state_s next_st;

  // Decode one area from its raw fields
  function automatic brc_area_s decode_area(input logic sel, input logic byte_sel,
                                            input logic [2:0] cyc, input logic [1:0] wrd);
    brc_area_s a;
    if (sel)
      a.if_kind = BRC_IF_BURST_ROM;                                  // RQ1
    else if (byte_sel)
      a.if_kind = BRC_IF_BYTE_SRAM;                                  // RQ11
    else
      a.if_kind = BRC_IF_BASIC;
    a.burst_cycles = BRC_BEATS_W'({1'b0, cyc}) + 4'h1;               // RQ3
    a.burst_words  = BRC_MIN_WORDS << wrd;                           // RQ4
    return a;
  endfunction

  logic [15:0] r;
  assign r = st.burst_rom_control;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Settings are sampled only at access start so a write never
  // changes an access already under way
  always_comb
  begin
    next_st = st;
    if (wr_req.wr_en)
      next_st.burst_rom_control = wr_req.wr_data & BRC_WRITE_MASK;   // RQ9
    if (area0_access_start)                                          // RQ12
      next_st.a0 = decode_area(r[BRC_A0_SEL_POS], area0_byte_sram_select,
                               r[BRC_A0_CYC_POS +: BRC_CYC_W], r[BRC_A0_WRD_POS +: BRC_WRD_W]);
    if (area1_access_start)                                          // RQ12
      next_st.a1 = decode_area(r[BRC_A1_SEL_POS], area1_byte_sram_select,   // RQ5
                               r[BRC_A1_CYC_POS +: BRC_CYC_W], r[BRC_A1_WRD_POS +: BRC_WRD_W]); // RQ7 RQ8
  end

  // Register the state; reset gives basic interface, 1 cycle, 4 words
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.burst_rom_control <= BRC_RESET_VALUE;                       // RQ10
      st.a0 <= '{BRC_IF_BASIC, 4'h1, BRC_MIN_WORDS};
      st.a1 <= '{BRC_IF_BASIC, 4'h1, BRC_MIN_WORDS};
    end
    else
      st <= next_st;
  end

  assign rd_data   = st.burst_rom_control;
  assign area0_cfg = st.a0;
  assign area1_cfg = st.a1;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_n) (rd_data & ~BRC_WRITE_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero"); // RQ9

  property p_write_stores;
    @(posedge clk) disable iff (!rst_n) wr_req.wr_en |=> rd_data == ($past(wr_req.wr_data) & BRC_WRITE_MASK);
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("write not stored"); // RQ9

  property p_a0_sel;
    @(posedge clk) disable iff (!rst_n)
      area0_access_start && rd_data[15] |=> area0_cfg.if_kind == BRC_IF_BURST_ROM;
  endproperty
  a_a0_sel: assert property (p_a0_sel) else $error("area 0 select wrong"); // RQ1

  property p_a0_cyc;
    @(posedge clk) disable iff (!rst_n)
      area0_access_start |=> area0_cfg.burst_cycles == $past(rd_data[14:12]) + 4'h1;
  endproperty
  a_a0_cyc: assert property (p_a0_cyc) else $error("area 0 cycles wrong"); // RQ3

  property p_a0_wrd;
    @(posedge clk) disable iff (!rst_n)
      area0_access_start && rd_data[9:8] == 2'h3 |=> area0_cfg.burst_words == 6'h20;
  endproperty
  a_a0_wrd: assert property (p_a0_wrd) else $error("area 0 words wrong"); // RQ4

  property p_a1_sel;
    @(posedge clk) disable iff (!rst_n)
      area1_access_start && rd_data[7] |=> area1_cfg.if_kind == BRC_IF_BURST_ROM;
  endproperty
  a_a1_sel: assert property (p_a1_sel) else $error("area 1 select wrong"); // RQ5

  property p_a1_cyc;
    @(posedge clk) disable iff (!rst_n)
      area1_access_start |=> area1_cfg.burst_cycles == $past(rd_data[6:4]) + 4'h1;
  endproperty
  a_a1_cyc: assert property (p_a1_cyc) else $error("area 1 cycles wrong"); // RQ7

  property p_a1_wrd;
    @(posedge clk) disable iff (!rst_n)
      area1_access_start && rd_data[1:0] == 2'h0 |=> area1_cfg.burst_words == 6'h04;
  endproperty
  a_a1_wrd: assert property (p_a1_wrd) else $error("area 1 words wrong"); // RQ8

  property p_hold;
    @(posedge clk) disable iff (!rst_n) !area0_access_start |=> $stable(area0_cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("area 0 changed mid access"); // RQ12

  property p_byte;
    @(posedge clk) disable iff (!rst_n)
      area1_access_start && !rd_data[7] && area1_byte_sram_select |=> area1_cfg.if_kind == BRC_IF_BYTE_SRAM;
  endproperty
  a_byte: assert property (p_byte) else $error("area 1 byte sram wrong"); // RQ11

  // First edge after power-up is skipped: the async clear may not have landed yet
  property p_reset_value;
    @(posedge clk) !rst_n && $past(!rst_n) |->
      rd_data == BRC_RESET_VALUE && area0_cfg.if_kind == BRC_IF_BASIC && area1_cfg.if_kind == BRC_IF_BASIC &&
      area0_cfg.burst_cycles == 4'h1 && area1_cfg.burst_cycles == 4'h1 &&
      area0_cfg.burst_words == BRC_MIN_WORDS && area1_cfg.burst_words == BRC_MIN_WORDS;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset value wrong"); // RQ10

  property p_a1_hold;
    @(posedge clk) disable iff (!rst_n) !area1_access_start |=> $stable(area1_cfg);
  endproperty
  a_a1_hold: assert property (p_a1_hold) else $error("area 1 changed mid access"); // RQ12

  property p_a0_byte;
    @(posedge clk) disable iff (!rst_n)
      area0_access_start && !rd_data[15] && area0_byte_sram_select |=> area0_cfg.if_kind == BRC_IF_BYTE_SRAM;
  endproperty
  a_a0_byte: assert property (p_a0_byte) else $error("area 0 byte sram wrong"); // RQ11

  property p_a0_basic;
    @(posedge clk) disable iff (!rst_n)
      area0_access_start && !rd_data[15] && !area0_byte_sram_select |=> area0_cfg.if_kind == BRC_IF_BASIC;
  endproperty
  a_a0_basic: assert property (p_a0_basic) else $error("area 0 basic wrong"); // RQ1

  property p_a1_basic;
    @(posedge clk) disable iff (!rst_n)
      area1_access_start && !rd_data[7] && !area1_byte_sram_select |=> area1_cfg.if_kind == BRC_IF_BASIC;
  endproperty
  a_a1_basic: assert property (p_a1_basic) else $error("area 1 basic wrong"); // RQ5

  property p_a0_wrd_all;
    @(posedge clk) disable iff (!rst_n)
      area0_access_start |=> area0_cfg.burst_words == (6'h04 << $past(rd_data[9:8]));
  endproperty
  a_a0_wrd_all: assert property (p_a0_wrd_all) else $error("area 0 word limit wrong"); // RQ4

  property p_a1_wrd_all;
    @(posedge clk) disable iff (!rst_n)
      area1_access_start |=> area1_cfg.burst_words == (6'h04 << $past(rd_data[1:0]));
  endproperty
  a_a1_wrd_all: assert property (p_a1_wrd_all) else $error("area 1 word limit wrong"); // RQ8

  // A write followed at once by a start: that start must see the new value,
  // so the one-cycle register latency never hides a setting from software
  sequence s_write;
    wr_req.wr_en;
  endsequence

  sequence s_a0_start;
    area0_access_start;
  endsequence

  sequence s_a1_start;
    area1_access_start;
  endsequence

  property p_a0_after_write;
    @(posedge clk) disable iff (!rst_n)
      s_write ##1 s_a0_start |=> area0_cfg.burst_cycles == {1'b0, $past(wr_req.wr_data[14:12], 2)} + 4'h1;
  endproperty
  a_a0_after_write: assert property (p_a0_after_write) else $error("area 0 missed new setting"); // RQ12

  property p_a1_after_write;
    @(posedge clk) disable iff (!rst_n)
      s_write ##1 s_a1_start |=> area1_cfg.burst_cycles == {1'b0, $past(wr_req.wr_data[6:4], 2)} + 4'h1;
  endproperty
  a_a1_after_write: assert property (p_a1_after_write) else $error("area 1 missed new setting"); // RQ12

endmodule // brc_regs
`default_nettype wire

// *** testbench/brc_far_model.sv ***
`default_nettype none
// ****
// Far side: access sequencer and SRAM mode bits
// ****
module brc_far_model
(
  // Clock
  input  wire logic       clk,
  // Requests from the bench, index 0 is area 0
  input  wire logic [1:0] start_req,
  input  wire logic [1:0] sram_req,
  input  wire logic [1:0] burst_sel,
  // Towards the register block
  output logic [1:0]      start,
  output logic [1:0]      byte_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  // Software drops the SRAM select while burst ROM is chosen
  assign byte_sel = sram_req & ~burst_sel;
  // Start pulse one cycle after the request
  always_ff @(posedge clk)
  begin
    start <= start_req;
  end
endmodule // brc_far_model
`default_nettype wire

// *** testbench/burst_rom_area_config_test.sv ***
`default_nettype none
// ****
// Bench: random writes, then access starts
// ****
module burst_rom_area_config_test
  import brc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_n;
  brc_wr_s     wr_req;
  logic [15:0] rd_data, exp_reg;
  logic [1:0]  start_req, sram_req, start, byte_sel;
  brc_area_s   cfg0, cfg1, old0, old1;
  int          num_errors, cmp_count;

  brc_regs brc_regs_i (.clk(clk), .rst_n(rst_n), .wr_req(wr_req), .rd_data(rd_data),
    .area0_byte_sram_select(byte_sel[0]), .area1_byte_sram_select(byte_sel[1]),
    .area0_access_start(start[0]), .area1_access_start(start[1]), .area0_cfg(cfg0), .area1_cfg(cfg1));
  brc_far_model brc_far_model_i (.clk(clk), .start_req(start_req), .sram_req(sram_req),
    .burst_sel({exp_reg[7], exp_reg[15]}), .start(start), .byte_sel(byte_sel));

  // Reference decode, kept apart from the design's own
  function automatic brc_area_s model(int sel, int bs, int c, int w);
    brc_area_s m;
    m.if_kind      = brc_if_e'(sel ? 2 : bs);
    m.burst_cycles = 4'(c + 1);
    m.burst_words  = 6'(4 << w);
    return m;
  endfunction

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write, check readback, then start both areas and check settings
  task automatic run(logic [15:0] d, logic [1:0] s);
    @(posedge clk);
    wr_req   <= '{1'b1, d};
    sram_req <= s;
    @(posedge clk);
    wr_req.wr_en <= 1'b0;
    start_req    <= 2'b11;
    exp_reg      <= d & 16'hF3F3;
    #1 chk(rd_data, d & 16'hF3F3);
    chk(16'(cfg0), 16'(old0));
    chk(16'(cfg1), 16'(old1));
    @(posedge clk);
    start_req <= 2'b00;
    @(posedge clk);
    old0 = model(exp_reg[15], s[0], exp_reg[14:12], exp_reg[9:8]);
    old1 = model(exp_reg[7], s[1], exp_reg[6:4], exp_reg[1:0]);
    #1 chk(16'(cfg0), 16'(old0));
    chk(16'(cfg1), 16'(old1));
    $display("test done data=%h sram=%b", d, s);
  endtask

  // Write while both areas start: that start keeps the old value,
  // the start one edge later picks up the new one
  task automatic clash(logic [15:0] d);
    @(posedge clk);
    start_req <= 2'b11;
    @(posedge clk);
    wr_req <= '{1'b1, d};
    @(posedge clk);
    wr_req.wr_en <= 1'b0;
    start_req    <= 2'b00;
    exp_reg      <= d & 16'hF3F3;
    #1 chk(16'(cfg0), 16'(old0));
    chk(16'(cfg1), 16'(old1));
    chk(rd_data, exp_reg);
    old0 = model(exp_reg[15], sram_req[0], exp_reg[14:12], exp_reg[9:8]);
    old1 = model(exp_reg[7], sram_req[1], exp_reg[6:4], exp_reg[1:0]);
    @(posedge clk);
    #1 chk(16'(cfg0), 16'(old0));
    chk(16'(cfg1), 16'(old1));
    $display("test done clash data=%h", d);
  endtask

  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Clock, 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog well past the expected run length
  initial
  begin
    #(25 * 2000);
    num_errors++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    wr_req = '0;
    start_req = 2'b00;
    sram_req = 2'b00;
    exp_reg = 16'h0000;
    void'($urandom(32'hB1CED59E));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    old0 = model(0, 0, 0, 0);
    old1 = old0;
    #1 chk(rd_data, 16'h0000);
    chk(16'(cfg0), 16'(old0));
    chk(16'(cfg1), 16'(old1));
    // Every cycle and word code, reserved bits written high
    for (int i = 0; i < 8; i++)
      run({i[0], i[2:0], 2'b11, i[1:0], ~i[0], ~i[2:0], 2'b11, ~i[1:0]}, i[2:1]);
    for (int i = 0; i < 16; i++)
    begin
      run(16'($urandom), 2'($urandom));
      clash(~exp_reg);
    end
    stop_test();
  end
endmodule // burst_rom_area_config_test
`default_nettype wire
